// ### rtl/smc_ctrl.sv
/*
 Sleep-mode controller: takes the sleep instruction from the core, gates the
 clock domains by mode, detects mode-specific wake sources and sequences
 start-up delay and, for interrupt wakes, core halt before release.
 Assumes the core raises sleep_exec for one cycle, inputs are synchronous,
 and the start-up count for deep modes is supplied by the clock-source logic.
*/
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// - Sleep only if enable bit set at instruction
// - Interrupt wake: start-up plus four halt cycles
// - Registers and memory untouched across sleep
// - Reset while asleep restarts from reset vector
// - Code 000 Idle: stop core, program clocks
// - Idle wakes on any enabled interrupt
// - Idle or noise mode starts a conversion
// - Code 001 noise mode: stop io, core
// - Noise mode wakes on listed sources only
// - Code 010 power-down: all generated clocks stop
// - Power-down wakes on reset, start, level, pin
// - Outside Idle, ext zero wakes only level-sensed
// - Power-down wake waits clock-source start-up time
// - Code 011 power-save keeps timer two, display
// - Power-save also wakes on timer two, display
// - Power-save stops timer osc unless async user
// - Power-save stops main clock unless sync user
// - Timer osc runs only for async users
// - Code 110 standby: oscillator on, six-cycle wake
// - Codes 100, 101, 111 are reserved
module smc_ctrl (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Register port
    input  wire logic [3:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // Core side
    input  wire logic             sleep_exec,
    input  wire logic             xtal_selected,
    input  wire logic [15:0]      startup_cycles,
    input  wire smc_pkg::smc_wake_t wake_in,
    input  wire logic             ext0_level_mode,
    input  wire logic             t2_async,
    input  wire logic             disp_async,
    input  wire logic             t2_enabled,
    input  wire logic             disp_enabled,
    input  wire logic             conv_enabled,
    output smc_pkg::smc_clk_en_t  clk_en,
    output logic                  conv_start,
    output logic                  core_hold,
    output logic                  irq_resume,
    output logic                  reset_restart,
    output logic                  sleep_reject
);
    import smc_pkg::*;

    smc_state_t  state_q;             // Controller state
    smc_state_t  state_d;
    logic [2:0]  mode_sel_q;          // Software mode select
    logic        sleep_enable_q;      // Software enable bit
    logic [2:0]  act_mode_q;          // Mode latched at entry
    logic [15:0] cnt_q;               // Start-up / halt counter
    logic [15:0] cnt_d;
    logic        rst_wake_q;          // Wake came from a reset
    logic [7:0]  rdata_q;             // Read data, one cycle late
    logic        conv_start_q;
    logic        resume_q;
    logic        rst_restart_q;
    logic        reject_q;

    // Decoded register accesses
    wire         wr_ctl    = reg_wr && (reg_addr == SMC_REG_ADDR);
    wire         rd_ctl    = reg_rd && (reg_addr == SMC_REG_ADDR);
    wire         rd_stat   = reg_rd && (reg_addr == SMC_STAT_ADDR);

    // Mode decode of the latched mode
    wire         m_idle    = (act_mode_q == SMC_MODE_IDLE);
    wire         m_noise   = (act_mode_q == SMC_MODE_NOISE);
    wire         m_pdown   = (act_mode_q == SMC_MODE_PDOWN);
    wire         m_psave   = (act_mode_q == SMC_MODE_PSAVE);
    wire         m_stby    = (act_mode_q == SMC_MODE_STANDBY);

    // Entry check on the live select; standby needs a crystal
    wire         sel_valid = (mode_sel_q <= SMC_MODE_PSAVE) ||
                             ((mode_sel_q == SMC_MODE_STANDBY) && xtal_selected);
    wire         go_sleep  = sleep_exec && sleep_enable_q && sel_valid;
    wire         no_op     = sleep_exec && !sleep_enable_q;

    // External interrupt zero: outside Idle only when level sensed
    wire         ext0_ok   = wake_in.ext0 && ext0_level_mode;
    wire         deep_wake = wake_in.rst_any || wake_in.start_cond ||
                             ext0_ok || wake_in.pin_change;
    wire         noise_wk  = deep_wake || wake_in.conv_done || wake_in.disp_irq ||
                             wake_in.t2_irq || wake_in.mem_ready;
    wire         save_wk   = deep_wake || wake_in.t2_irq || wake_in.disp_irq;
    wire         wake_hit  = (m_idle  && (wake_in.any_irq || wake_in.rst_any)) ||
                             (m_noise && noise_wk) ||
                             ((m_pdown || m_stby) && deep_wake) ||
                             (m_psave && save_wk);

    // Start-up length: standby fixed six, power-down and power-save clock-source time, else one
    wire  [15:0] startup_len = m_stby ? {11'h000, SMC_STBY_CYC} :
                               ((m_pdown || m_psave) ? startup_cycles : 16'h0001);
    wire         cnt_done  = (cnt_q <= 16'h0001);

    // Asleep in a given mode
    wire         asleep    = (state_q == SMC_SLEEP) || (state_q == SMC_START);
    wire         async_use = t2_async || disp_async;
    wire         sync_use  = (t2_enabled && !t2_async) || (disp_enabled && !disp_async);

    // Clock gating: core and program memory only in run
    // Registers and memory keep their contents; only clocks stop.
    always_comb begin
        clk_en           = '0;
        clk_en.core      = !asleep && (state_q != SMC_HALT);
        clk_en.progmem   = clk_en.core;
        clk_en.timer_osc = async_use;
        if (!asleep) begin
            // Running or halted: io, converter, async and main osc on; timer osc by async use
            clk_en.io       = 1'b1;
            clk_en.conv     = 1'b1;
            clk_en.async    = 1'b1;
            clk_en.main_osc = 1'b1;
        end else if (m_idle) begin
            clk_en.io       = 1'b1;
            clk_en.conv     = 1'b1;
            clk_en.async    = 1'b1;
            clk_en.main_osc = 1'b1;
        end else if (m_noise) begin
            clk_en.conv     = 1'b1;
            clk_en.async    = 1'b1;
            clk_en.main_osc = 1'b1;
        end else if (m_psave) begin
            // Main clock only fed to timer two and display
            clk_en.async    = async_use;
            clk_en.main_osc = sync_use;
        end else if (m_stby) begin
            clk_en.main_osc = 1'b1;
            clk_en.timer_osc = 1'b0;
        end else begin
            // Power-down: only asynchronous logic survives
            clk_en.timer_osc = 1'b0;
        end
        // Restart phase needs the oscillator back
        if (state_q == SMC_START) begin
            clk_en.main_osc = 1'b1;
        end
    end

    // Next-state logic
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            SMC_RUN: begin
                if (go_sleep) begin
                    state_d = SMC_SLEEP;
                end
            end
            SMC_SLEEP: begin
                if (wake_hit) begin
                    state_d = SMC_START;
                    cnt_d   = startup_len;
                end
            end
            SMC_START: begin
                // Reset wakes skip the halt, go straight to run
                if (cnt_done) begin
                    state_d = rst_wake_q ? SMC_RUN : SMC_HALT;
                    cnt_d   = {11'h000, SMC_HALT_CYC};
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            SMC_HALT: begin
                if (cnt_done) begin
                    state_d = SMC_RUN;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            default: begin
                state_d = SMC_RUN;
            end
        endcase
    end

    // State and counter
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= SMC_RUN;
            cnt_q   <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Mode latched at entry; wake cause latched at wake
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            act_mode_q <= SMC_MODE_IDLE;
            rst_wake_q <= 1'b0;
        end else begin
            if (go_sleep && state_q == SMC_RUN) begin
                act_mode_q <= mode_sel_q;
            end
            if (state_q == SMC_SLEEP && wake_hit) begin
                rst_wake_q <= wake_in.rst_any;
            end
        end
    end

    // Control register; enable and mode written by software
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sleep_enable_q <= SMC_REG_RESET[SMC_EN_BIT];
            mode_sel_q     <= SMC_REG_RESET[3:1];
        end else if (wr_ctl) begin
            sleep_enable_q <= reg_wdata[SMC_EN_BIT];
            mode_sel_q     <= reg_wdata[SMC_MODE_LSB +: 3];
        end
    end

    // Read data: control word or controller state
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (rd_ctl) begin
            rdata_q <= {4'h0, mode_sel_q, sleep_enable_q};
        end else if (rd_stat) begin
            rdata_q <= {3'h0, state_q};
        end else begin
            rdata_q <= 8'h00;                                          // Unmapped reads zero
        end
    end

    // One-cycle event outputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            conv_start_q  <= 1'b0;
            resume_q      <= 1'b0;
            rst_restart_q <= 1'b0;
            reject_q      <= 1'b0;
        end else begin
            // Conversion kicks off as the quiet mode is entered
            conv_start_q  <= go_sleep && conv_enabled && (state_q == SMC_RUN) &&
                             (mode_sel_q == SMC_MODE_IDLE || mode_sel_q == SMC_MODE_NOISE);
            resume_q      <= (state_q == SMC_HALT) && cnt_done;
            rst_restart_q <= (state_q == SMC_START) && cnt_done && rst_wake_q;
            reject_q      <= (no_op || (sleep_exec && !sel_valid)) && (state_q == SMC_RUN);
        end
    end

    assign reg_rdata     = rdata_q;
    assign conv_start    = conv_start_q;
    assign core_hold     = (state_q != SMC_RUN);
    assign irq_resume    = resume_q;
    assign reset_restart = rst_restart_q;
    assign sleep_reject  = reject_q;

    // Halt length counter for checking
    logic [3:0] halt_len_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst || state_q != SMC_HALT) begin
            halt_len_q <= 4'h0;
        end else begin
            halt_len_q <= halt_len_q + 4'h1;
        end
    end

    // Rule checks, one per guarded rule

    // Entry needs the enable bit
    a_enable_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_RUN && sleep_exec && !sleep_enable_q) |=> state_q == SMC_RUN)
        else $error("sleep entered with enable clear");

    // Refused sleep keeps clocks
    a_noop_clocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_RUN && no_op) |=> clk_en.core && sleep_reject)
        else $error("no-op sleep stopped clocks");

    // Four-cycle core halt
    a_halt_four: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(state_q == SMC_HALT) |-> halt_len_q == 4'h4)
        else $error("core halt not four cycles");

    // Reset wake skips the halt
    a_reset_vector: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reset_restart |-> !irq_resume && state_q == SMC_RUN)
        else $error("reset wake not sent to reset vector");

    // Idle clock set
    a_idle_clocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && m_idle) |-> !clk_en.core && clk_en.io && clk_en.conv)
        else $error("idle clock set wrong");

    // Noise mode clock set
    a_noise_clocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && m_noise) |-> !clk_en.io && clk_en.conv && clk_en.main_osc)
        else $error("noise mode clock set wrong");

    // Power-down stops everything
    a_pdown_clocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && m_pdown) |-> clk_en == '0)
        else $error("power-down left a clock running");

    // Edge-sensed ext zero stays asleep
    a_edge_ext0: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && m_pdown && wake_in.ext0 && !ext0_level_mode &&
         !wake_in.rst_any && !wake_in.start_cond && !wake_in.pin_change)
        |=> state_q == SMC_SLEEP)
        else $error("edge ext zero woke deep mode");

    // Standby wakes in six
    a_standby_six: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && m_stby && wake_hit) |=> state_q == SMC_START [*6] ##1 state_q != SMC_START)
        else $error("standby wake not six cycles");

    // Reserved codes never sleep
    a_reserved_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_RUN && sleep_exec && mode_sel_q[2] && mode_sel_q != SMC_MODE_STANDBY)
        |=> state_q == SMC_RUN)
        else $error("reserved mode entered sleep");

    // Conversion on idle entry
    a_conv_kick: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_RUN && go_sleep && conv_enabled && mode_sel_q == SMC_MODE_IDLE) |=> conv_start)
        else $error("conversion not started on idle entry");

    // Timer osc follows async users
    a_psave_osc: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && m_psave && !async_use) |-> !clk_en.timer_osc)
        else $error("timer osc ran without async user");

    // Idle wakes on any interrupt
    a_idle_wake: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && m_idle && wake_in.any_irq) |=> state_q == SMC_START)
        else $error("idle missed an interrupt");

    // A plain interrupt cannot end noise mode
    a_noise_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && m_noise && wake_in == 9'h100) |=> state_q == SMC_SLEEP)
        else $error("noise mode woke on a plain interrupt");

    // Deep sources end power-down
    a_pdown_wake: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && m_pdown && (wake_in.rst_any || wake_in.start_cond || wake_in.pin_change))
        |=> state_q == SMC_START)
        else $error("power-down missed a wake source");

    // Timer or display ends power-save
    a_psave_wake: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && m_psave && (wake_in.t2_irq || wake_in.disp_irq)) |=> state_q == SMC_START)
        else $error("power-save missed timer or display");

    // Start-up of three from the clock source
    a_start_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && m_pdown && wake_hit && startup_cycles == 16'h0003)
        |=> state_q == SMC_START [*3] ##1 state_q != SMC_START)
        else $error("power-down start-up length wrong");

    // Timer osc off with no async user
    a_timer_osc: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == SMC_SLEEP && !t2_async && !disp_async) |-> !clk_en.timer_osc)
        else $error("timer osc ran with no async user");

    // Sleep leaves the control word alone
    a_ctrl_kept: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q != SMC_RUN && !wr_ctl) |=> $stable(mode_sel_q) && $stable(sleep_enable_q))
        else $error("control word changed in sleep");

    // Main scenarios seen
    c_idle_wake:  cover property (@(posedge ref_clk) state_q == SMC_SLEEP && m_idle ##1 state_q == SMC_START);
    c_pdown_wake: cover property (@(posedge ref_clk) state_q == SMC_SLEEP && m_pdown ##1 state_q == SMC_START);
    c_rst_wake:   cover property (@(posedge ref_clk) reset_restart);
    c_resume:     cover property (@(posedge ref_clk) irq_resume);
endmodule

// ### rtl/smc_pkg.sv
/*
 Package for the sleep-mode controller: mode codes, state encoding,
 timing counts and the packed carriers for clock gates and wake sources.
 Assumes a single 50 MHz system clock and synchronous inputs.
*/
package smc_pkg;
    // Mode codes of the three-bit mode select
    localparam logic [2:0] SMC_MODE_IDLE    = 3'h0;
    localparam logic [2:0] SMC_MODE_NOISE   = 3'h1;
    localparam logic [2:0] SMC_MODE_PDOWN   = 3'h2;
    localparam logic [2:0] SMC_MODE_PSAVE   = 3'h3;
    localparam logic [2:0] SMC_MODE_STANDBY = 3'h6;

    // Register layout: bit 0 enable, bits 3:1 mode
    localparam logic [3:0] SMC_REG_ADDR   = 4'h0;
    localparam logic [3:0] SMC_STAT_ADDR  = 4'h1;
    localparam int         SMC_EN_BIT     = 0;
    localparam int         SMC_MODE_LSB   = 1;
    localparam logic [3:0] SMC_REG_RESET  = 4'h0;

    // Timing: clock period and fixed counts
    localparam int         SMC_CLK_NS     = 20;
    localparam logic [4:0] SMC_HALT_CYC   = 5'h04;   // Core halt after wake
    localparam logic [4:0] SMC_STBY_CYC   = 5'h06;   // Standby wake time
    localparam logic [4:0] SMC_ONE        = 5'h01;

    // Controller states, one-hot
    typedef enum logic [4:0] {
        SMC_RUN   = 5'b00001,
        SMC_SLEEP = 5'b00010,
        SMC_START = 5'b00100,
        SMC_HALT  = 5'b01000,
        SMC_RESV  = 5'b10000
    } smc_state_t;

    // Clock domain and oscillator enables
    typedef struct packed {
        logic core;
        logic progmem;
        logic io;
        logic conv;
        logic async;
        logic main_osc;
        logic timer_osc;
    } smc_clk_en_t;

    // Wake sources as seen by the controller
    typedef struct packed {
        logic any_irq;       // Any enabled interrupt (Idle)
        logic conv_done;
        logic rst_any;       // External, watchdog or brown-out reset
        logic disp_irq;
        logic start_cond;
        logic t2_irq;        // Timer-two overflow or compare, masked
        logic mem_ready;
        logic ext0;          // External interrupt zero asserted
        logic pin_change;
    } smc_wake_t;
endpackage

// ### test/smc_wake_model.sv
/*
 Wake-source model: stands for the interrupt sources and asynchronous
 peripherals that wake the sleep-mode controller.
 Assumes the bench asks for a wake by a one-cycle request vector.
*/
`timescale 1ns/10ps
module smc_wake_model (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              core_hold,
    input  wire logic [8:0]        wake_req,
    output smc_pkg::smc_wake_t     wake_in
);
    import smc_pkg::*;

    logic [8:0] wake_q;  // Held wake levels
    logic [8:0] wake_d;  // Next wake levels

    // Level stays until the core runs again, so a slow wake is never lost
    assign wake_d = core_hold ? (wake_q | wake_req) : 9'h000;

    // Levels register on the system clock
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wake_q <= 9'h000;
        end else begin
            wake_q <= wake_d;
        end
    end

    assign wake_in = smc_wake_t'(wake_q);
endmodule

// ### test/tb_sleep_mode_controller.sv
/*
 Self-checking bench for the sleep-mode controller: reset test, table of
 sleep and wake cases, then refusal and wrong-source tests.
 Assumes a 50 MHz clock and startup_cycles of three unless a test moves it.
*/
`timescale 1ns/10ps
module tb_sleep_mode_controller;
    import smc_pkg::*;

    // One table row: mode, crystal, converter, wake, clocks, latency, irq
    typedef struct {
        logic [2:0] mode;
        logic       xtal;
        logic       conv;
        logic [8:0] wk;
        logic [6:0] clk;
        int         lat;
        logic       irq;
    } smc_row_t;

    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        sleep_exec = 1'b0;
    logic        xtal_selected = 1'b0;
    logic        ext0_level_mode = 1'b1;
    logic        t2_async = 1'b1;
    logic        disp_async = 1'b1;
    logic        t2_enabled = 1'b1;
    logic        disp_enabled = 1'b1;
    logic [15:0] startup_cycles = 16'h0003;
    logic        conv_enabled = 1'b0;
    logic [8:0]  wake_req = 9'h000;
    smc_wake_t   wake_in;
    smc_clk_en_t clk_en;
    logic        conv_start;
    logic        core_hold;
    logic        irq_resume;
    logic        reset_restart;
    logic        sleep_reject;
    int          fails = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          n;
    logic        rej;
    logic        cs;
    smc_row_t    rows [9];

    // Clock, 20 ns period
    always #10 ref_clk = ~ref_clk;

    // Hang guard, far above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            give_verdict();
        end
    end

    smc_wake_model u_wake (.ref_clk(ref_clk), .sys_rst(sys_rst), .core_hold(core_hold),
                           .wake_req(wake_req), .wake_in(wake_in));

    smc_ctrl DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
                  .xtal_selected(xtal_selected), .startup_cycles(startup_cycles), .wake_in(wake_in),
                  .ext0_level_mode(ext0_level_mode), .t2_async(t2_async), .disp_async(disp_async),
                  .t2_enabled(t2_enabled), .disp_enabled(disp_enabled), .conv_enabled(conv_enabled),
                  .clk_en(clk_en), .conv_start(conv_start), .core_hold(core_hold),
                  .irq_resume(irq_resume), .reset_restart(reset_restart), .sleep_reject(sleep_reject));

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // One-cycle register write
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read strobe, data taken in the following cycle only
    task automatic reg_read(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk({8'h00, reg_rdata}, {8'h00, exp}, what);
    endtask

    // Sleep instruction pulse; conversion start seen in either next cycle
    task automatic sleep_go(output logic rj, output logic c);
        @(posedge ref_clk);
        sleep_exec <= 1'b1;
        @(posedge ref_clk);
        sleep_exec <= 1'b0;
        #1;
        rj = sleep_reject;
        c = conv_start;
        @(posedge ref_clk);
        #1 c = c | conv_start;
    endtask

    // Raise a wake request, count edges to the resume or restart pulse
    task automatic wake_go(input logic [8:0] v, input logic irq, output int cnt);
        cnt = 0;
        @(posedge ref_clk);
        wake_req <= v;
        do begin
            @(posedge ref_clk);
            cnt++;
            wake_req <= 9'h000;
            #1;
        end while (((irq ? irq_resume : reset_restart) !== 1'b1) && cnt < 40);
    endtask

    // Wrong source must not wake; then a right one does
    task automatic blocked(input logic [2:0] m, input logic [8:0] bad, input logic [8:0] good, input int lat);
        reg_write(SMC_REG_ADDR, {4'h0, m, 1'b1});
        sleep_go(rej, cs);
        @(posedge ref_clk);
        wake_req <= bad;
        repeat (20) @(posedge ref_clk);
        #1 chk({15'h0, core_hold}, 16'h0001, "wrong source woke");
        wake_go(good, 1'b1, n);
        chk(n[15:0], lat[15:0], "wake after wrong source");
    endtask

    // Closing report
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rows[0] = '{3'h0, 1'b0, 1'b1, 9'h100, 7'h1F, 7, 1'b1};
        rows[1] = '{3'h1, 1'b0, 1'b1, 9'h080, 7'h0F, 7, 1'b1};
        rows[2] = '{3'h2, 1'b0, 1'b1, 9'h010, 7'h00, 9, 1'b1};
        rows[3] = '{3'h3, 1'b0, 1'b0, 9'h008, 7'h05, 9, 1'b1};
        rows[4] = '{3'h6, 1'b1, 1'b0, 9'h001, 7'h02, 12, 1'b1};
        rows[5] = '{3'h2, 1'b0, 1'b0, 9'h002, 7'h00, 9, 1'b1};
        rows[6] = '{3'h2, 1'b0, 1'b0, 9'h040, 7'h00, 5, 1'b0};
        rows[7] = '{3'h3, 1'b0, 1'b0, 9'h020, 7'h05, 9, 1'b1};
        rows[8] = '{3'h0, 1'b0, 1'b0, 9'h040, 7'h1F, 3, 1'b0};
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Reset values and an unmapped place
        reg_read(SMC_REG_ADDR, 8'h00, "control after reset");
        reg_read(SMC_STAT_ADDR, 8'h01, "status after reset");
        reg_write(4'hF, 8'hFF);
        reg_read(4'hF, 8'h00, "unmapped read");
        reg_read(SMC_REG_ADDR, 8'h00, "control after stray write");
        chk({9'h0, clk_en}, 16'h007F, "clocks after reset");
        $display("reset test done");
        // Table of modes and wake sources
        foreach (rows[i]) begin
            xtal_selected <= rows[i].xtal;
            conv_enabled <= rows[i].conv;
            reg_write(SMC_REG_ADDR, {4'h0, rows[i].mode, 1'b1});
            sleep_go(rej, cs);
            chk({15'h0, rej}, 16'h0000, "valid sleep refused");
            chk({15'h0, cs}, {15'h0, rows[i].conv & (rows[i].mode < 3'h2)}, "conversion start");
            chk({9'h0, clk_en}, {9'h0, rows[i].clk}, "sleep clocks");
            chk({15'h0, core_hold}, 16'h0001, "core not held");
            reg_read(SMC_STAT_ADDR, 8'h02, "status asleep");
            wake_go(rows[i].wk, rows[i].irq, n);
            chk(n[15:0], rows[i].lat[15:0], "wake latency");
            chk({8'h0, core_hold, clk_en}, 16'h007F, "clocks after wake");
            if (rows[i].irq) begin
                reg_read(SMC_REG_ADDR, {4'h0, rows[i].mode, 1'b1}, "control kept");
            end
            $display("row %0d done", i);
        end
        // Sleep with enable clear is a no-op
        reg_write(SMC_REG_ADDR, 8'h00);
        sleep_go(rej, cs);
        chk({8'h0, rej, clk_en}, 16'h00FF, "enable clear");
        chk({15'h0, core_hold}, 16'h0000, "held with enable clear");
        $display("enable test done");
        // Reserved codes, and standby without a crystal
        xtal_selected <= 1'b0;
        foreach (rows[i]) begin
            if (i < 4) begin
                reg_write(SMC_REG_ADDR, {4'h0, (i == 3) ? 3'h6 : 3'h4 + i[2:0] + (i == 2), 1'b1});
                sleep_go(rej, cs);
                chk({7'h0, rej, core_hold, clk_en}, 16'h017F, "reserved code");
            end
        end
        $display("reserved test done");
        // Wrong sources in deep and noise modes
        ext0_level_mode <= 1'b0;
        blocked(SMC_MODE_PDOWN, 9'h102, 9'h001, 9);
        ext0_level_mode <= 1'b1;
        blocked(SMC_MODE_NOISE, 9'h100, 9'h004, 7);
        $display("source test done");
        // Power-save with both users on the main clock, then with none
        t2_async <= 1'b0;
        disp_async <= 1'b0;
        reg_write(SMC_REG_ADDR, {4'h0, SMC_MODE_PSAVE, 1'b1});
        sleep_go(rej, cs);
        chk({9'h0, clk_en}, 16'h0002, "sync users clocks");
        wake_go(9'h008, 1'b1, n);
        chk(n[15:0], 16'h0009, "sync users wake");
        t2_enabled <= 1'b0;
        disp_enabled <= 1'b0;
        startup_cycles <= 16'h0005;
        reg_write(SMC_REG_ADDR, {4'h0, SMC_MODE_PSAVE, 1'b1});
        sleep_go(rej, cs);
        chk({9'h0, clk_en}, 16'h0000, "no users clocks");
        wake_go(9'h001, 1'b1, n);
        chk(n[15:0], 16'h000B, "longer start-up wake");
        $display("clock user test done");
        give_verdict();
    end
endmodule
